// File: hw/psm_defines.vh
// constants of the supply monitor block
`ifndef PSM_DEFINES_VH
`define PSM_DEFINES_VH
`define PSM_CTRL_ADDR 8'hdf
`define PSM_CTRL_RESET 8'hde
`define PSM_BIT_DGOOD 7
`define PSM_BIT_AGOOD 6
`define PSM_BIT_FLAG 5
`define PSM_BIT_DTRIP_HI 4
`define PSM_BIT_DTRIP_LO 3
`define PSM_BIT_ATRIP_HI 2
`define PSM_BIT_ATRIP_LO 1
`define PSM_BIT_EN 0
`define PSM_CLK_HZ 10000000
`define PSM_RECOVER_MS 250
`define PSM_RECOVER_CYC ((`PSM_CLK_HZ / 1000) * `PSM_RECOVER_MS)
`define PSM_GLITCH_CYC 16
`endif

// File: hw/psm_filter.v
// glitch filter for one comparator input
`timescale 1ns/1ps
`include "psm_defines.vh"
module psm_filter #(
	parameter CNT_W = 5,
	parameter HOLD = `PSM_GLITCH_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire raw,
	output reg clean
);
	// ****************
	// synchroniser
	// ****************
	reg s1;
	reg s2;
	reg s3;
	reg [CNT_W-1:0] cnt;
	always @(posedge clk) begin
		if (!rst_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// ****************
	// stability count
	// ****************
	// a level must hold HOLD cycles before it is believed, so short dips pass unseen
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt <= {CNT_W{1'b0}};
			clean <= 1'b1;
		end else if (s2 != s3 || s3 == clean) begin
			cnt <= {CNT_W{1'b0}};
		end else if (cnt == HOLD[CNT_W-1:0] - 1'b1) begin // R10
			cnt <= {CNT_W{1'b0}};
			clean <= s3;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule // psm_filter

// File: hw/psm_monitor.v
// supply monitor control register, flag and recovery timer
// Summary of operation
// R1: monitoring runs only while control bit 0 is set
// R2: bit 7 reads the live digital supply comparator
// R3: bit 6 reads the live analog supply comparator
// R4: flag bit 5 sets when either comparator reads low
// R5: flag clears after both stay high for 250 ms
// R6: software may write the flag but cannot clear it while supply low
// R7: bits 4:3 select digital trip point 4.63/3.08/2.93/2.63 V
// R8: bits 2:1 select analog trip point with same encoding
// R9: interrupt request only when separate enable bit is set
// R10: comparator inputs are filtered against short glitches
// R11: high-voltage variant resets when digital supply under 4.63 V
// R12: while disabled, timer held in reset and flag not set
`timescale 1ns/1ps
`include "psm_defines.vh"
module psm_monitor #(
	parameter RECOVER_CYC = `PSM_RECOVER_CYC,
	parameter CNT_W = 22,
	parameter HIGH_VOLT_PART = 0
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	output reg [7:0] sfr_rdata,
	input wire digital_supply_raw,
	input wire analog_supply_raw,
	input wire digital_por_raw,
	input wire psm_irq_enable,
	output reg [1:0] digital_trip_sel,
	output reg [1:0] analog_trip_sel,
	output reg comparator_enable,
	output reg psm_irq,
	output reg por_request
);
	// ****************
	// state
	// ****************
	reg monitor_enable;
	reg low_supply_flag;
	reg [CNT_W-1:0] recover_cnt;
	wire digital_supply_good;
	wire analog_supply_good;
	wire por_clean;
	wire both_good;
	wire ctrl_wr;
	wire [7:0] ctrl_value;
	wire next_flag;
	localparam [7:0] CTRL_RST = `PSM_CTRL_RESET;
	// while monitoring is off the comparators only block a software clear of the flag
	assign both_good = digital_supply_good & analog_supply_good;
	assign ctrl_wr = sfr_wr && (sfr_addr == `PSM_CTRL_ADDR);
	assign ctrl_value = {digital_supply_good, analog_supply_good, low_supply_flag,
		digital_trip_sel, analog_trip_sel, monitor_enable};
	// ****************
	// input filters
	// ****************
	psm_filter u_dflt (
		.clk(clk),
		.rst_n(rst_n),
		.raw(digital_supply_raw),
		.clean(digital_supply_good)
	);
	psm_filter u_aflt (
		.clk(clk),
		.rst_n(rst_n),
		.raw(analog_supply_raw),
		.clean(analog_supply_good)
	);
	psm_filter u_pflt (
		.clk(clk),
		.rst_n(rst_n),
		.raw(digital_por_raw),
		.clean(por_clean)
	);
	// ****************
	// control register
	// ****************
	always @(posedge clk) begin
		if (!rst_n) begin
			monitor_enable <= CTRL_RST[`PSM_BIT_EN];
			digital_trip_sel <= CTRL_RST[`PSM_BIT_DTRIP_HI:`PSM_BIT_DTRIP_LO];
			analog_trip_sel <= CTRL_RST[`PSM_BIT_ATRIP_HI:`PSM_BIT_ATRIP_LO];
			comparator_enable <= CTRL_RST[`PSM_BIT_EN];
		end else if (ctrl_wr) begin
			monitor_enable <= sfr_wdata[`PSM_BIT_EN]; // R1
			comparator_enable <= sfr_wdata[`PSM_BIT_EN]; // R1
			digital_trip_sel <= sfr_wdata[`PSM_BIT_DTRIP_HI:`PSM_BIT_DTRIP_LO]; // R7
			analog_trip_sel <= sfr_wdata[`PSM_BIT_ATRIP_HI:`PSM_BIT_ATRIP_LO]; // R8
		end
	end
	// ****************
	// flag and recovery timer
	// ****************
	// hardware set beats a software clear in the same cycle
	assign next_flag = (monitor_enable && !both_good) ? 1'b1 : // R4 R12
		(ctrl_wr && (sfr_wdata[`PSM_BIT_FLAG] || both_good)) ? sfr_wdata[`PSM_BIT_FLAG] : // R6
		(low_supply_flag && monitor_enable && recover_cnt == RECOVER_CYC[CNT_W-1:0] - 1'b1)
		? 1'b0 : low_supply_flag; // R5
	always @(posedge clk) begin
		if (!rst_n) begin
			low_supply_flag <= 1'b0;
			recover_cnt <= {CNT_W{1'b0}};
		end else begin
			low_supply_flag <= next_flag;
			if (!monitor_enable || !both_good || !low_supply_flag) begin
				recover_cnt <= {CNT_W{1'b0}}; // R12
			end else if (recover_cnt != RECOVER_CYC[CNT_W-1:0] - 1'b1) begin
				recover_cnt <= recover_cnt + 1'b1; // R5
			end else begin
				recover_cnt <= {CNT_W{1'b0}};
			end
		end
	end
	// ****************
	// outputs
	// ****************
	always @(posedge clk) begin
		if (!rst_n) begin
			psm_irq <= 1'b0;
			por_request <= 1'b0;
			sfr_rdata <= 8'h00;
		end else begin
			psm_irq <= next_flag & psm_irq_enable; // R9
			por_request <= (HIGH_VOLT_PART != 0) && !por_clean; // R11
			if (sfr_addr == `PSM_CTRL_ADDR) begin
				sfr_rdata <= ctrl_value; // R2 R3
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end
endmodule // psm_monitor

// File: tb/psm_monitor_tb.sv
// self-checking bench of the supply monitor
`timescale 1ns/1ps
module psm_monitor_tb;
	reg clk = 0, rst_n = 0, sfr_wr = 0, psm_irq_enable = 0;
	reg [7:0] sfr_addr = 8'hdf, sfr_wdata = 0, c;
	reg [12:0] dv = 13'h1388, av = 13'h1388;
	reg [31:0] s = 96;
	wire [7:0] sfr_rdata;
	wire [1:0] digital_trip_sel, analog_trip_sel;
	wire digital_supply_raw, analog_supply_raw, digital_por_raw;
	wire comparator_enable, psm_irq, por_request;
	integer fails = 0, checked = 0, cyc = 0, i, n;
	localparam REC = 50;
	always #50 clk = ~clk;
	psm_supply_model m (.*);
	psm_monitor #(.RECOVER_CYC(REC), .HIGH_VOLT_PART(1)) i_psm_monitor (.*);
	always @(posedge clk) if (++cyc > 3000) begin
		fails++;
		results;
	end
	function [31:0] xs(input [31:0] v);
		xs = v ^ (v << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// trip levels in mV, one per select code
	function [12:0] trip(input [1:0] code);
		case (code)
			2'h0: trip = 13'h1216;
			2'h1: trip = 13'h0c08;
			2'h2: trip = 13'h0b72;
			default: trip = 13'h0a46;
		endcase
	endfunction
	task chk(input [8*16-1:0] nm, input [7:0] e, input [7:0] v);
		checked++;
		if (e !== v) begin
			fails++;
			$display("Error %0s expected %h seen %h", nm, e, v);
		end
	endtask
	task results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// read data lags the address by one cycle
	task rd(input [7:0] e);
		repeat (2) @(posedge clk);
		#1 chk("sfr_rdata", e, sfr_rdata);
		if (sfr_addr == 8'hdf) begin
			chk("trip_sel", e[4:1], {digital_trip_sel, analog_trip_sel});
			chk("comparator_en", e[0], comparator_enable);
			chk("psm_irq", e[5] & psm_irq_enable, psm_irq);
			chk("por_request", dv < trip(2'h0), por_request);
		end
		$display("read done %h", sfr_rdata);
		@(posedge clk);
	endtask
	task wr(input [7:0] d);
		sfr_wr <= 1;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 0;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		repeat (24) @(posedge clk);
		rd(8'hde);
		for (i = 0; i < 8; i++) begin
			s = xs(s);
			c = {3'h0, i[1:0], ~i[1:0], 1'b0};
			dv <= 13'h0a00 + s[20:10];
			av <= 13'h0a00 + s[31:21];
			wr(c);
			repeat (24) @(posedge clk);
			rd({dv >= trip(c[4:3]), av >= trip(c[2:1]), c[5:0]});
		end
		dv <= 13'h1388;
		av <= 13'h1388;
		repeat (24) @(posedge clk);
		psm_irq_enable <= 1;
		wr(8'h1f);
		av <= 13'h0800;
		repeat (6) @(posedge clk);
		av <= 13'h1388;
		rd(8'hdf);
		av <= 13'h0800;
		repeat (30) @(posedge clk);
		rd(8'hbf);
		wr(8'h1f);
		rd(8'hbf);
		wr(8'h1e);
		@(posedge clk);
		wr(8'h1e);
		rd(8'hbe);
		wr(8'h1f);
		av <= 13'h1388;
		repeat (40) @(posedge clk);
		rd(8'hff);
		// edges since the supplies came back
		n = 43;
		while (psm_irq !== 1'b0 && n < 200) begin
			@(posedge clk);
			#1 n = n + 1;
		end
		chk("recover_cyc", 3 + 16 + REC, n);
		rd(8'hdf);
		sfr_addr <= 8'h7f;
		rd(8'h00);
		results;
	end
endmodule // psm_monitor_tb

// File: tb/psm_properties.sv
// port checker of the supply monitor
`timescale 1ns/1ps
module psm_properties #(parameter HIGH_VOLT_PART = 0) (
	input wire clk, rst_n, sfr_wr, analog_supply_raw, psm_irq_enable, digital_por_raw,
	input wire [7:0] sfr_addr, sfr_wdata,
	input wire [1:0] digital_trip_sel, analog_trip_sel,
	input wire comparator_enable, psm_irq, por_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire w = sfr_wr && sfr_addr == 8'hdf;
	wire lo = comparator_enable && psm_irq_enable && !analog_supply_raw;
	// filter needs about 20 cycles, 24 leaves margin
	sequence low24;
		lo[*8] ##1 lo[*8] ##1 lo[*8];
	endsequence
	sequence por_good24;
		digital_por_raw[*8] ##1 digital_por_raw[*8] ##1 digital_por_raw[*8];
	endsequence
	en_copy_a: assert property (w |=> comparator_enable == $past(sfr_wdata[0])) else $error("en");
	dig_trip_a: assert property (w |=> digital_trip_sel == $past(sfr_wdata[4:3])) else $error("d");
	ana_trip_a: assert property (w |=> analog_trip_sel == $past(sfr_wdata[2:1])) else $error("a");
	irq_gate_a: assert property (!psm_irq_enable |=> !psm_irq) else $error("irq");
	low_flag_a: assert property (low24 |-> ##[0:4] psm_irq) else $error("low");
	flag_hold_a: assert property (low24 ##0 psm_irq |=> psm_irq) else $error("hold");
	por_off_a: assert property (por_good24 |-> !por_request) else $error("por");
	rst_val_a: assert property (disable iff (1'b0) !rst_n |=> !psm_irq) else $error("rst");
	cover property (w);
	cover property ($rose(psm_irq));
	cover property ($fell(psm_irq));
endmodule // psm_properties
bind psm_monitor psm_properties #(.HIGH_VOLT_PART(HIGH_VOLT_PART)) i_psm_properties (.*);

// File: tb/psm_supply_model.sv
// comparator model facing the supply monitor
`timescale 1ns/1ps
module psm_supply_model (
	input wire [12:0] dv, av,
	input wire [1:0] digital_trip_sel, analog_trip_sel,
	output wire digital_supply_raw, analog_supply_raw, digital_por_raw
);
	// trip levels in mV, one per code
	localparam [12:0] trip_mv [4] = '{13'h1216, 13'h0c08, 13'h0b72, 13'h0a46};
	assign digital_supply_raw = dv >= trip_mv[digital_trip_sel];
	assign analog_supply_raw = av >= trip_mv[analog_trip_sel];
	assign digital_por_raw = dv >= trip_mv[0];
endmodule // psm_supply_model
